// [pkg/ppb_pkg.sv]
package ppb_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int PORT_W = 8;

  // Register byte addresses
  localparam logic [7:0] ADDR_DATA_A   = 8'h00;
  localparam logic [7:0] ADDR_DATA_B   = 8'h04;
  localparam logic [7:0] ADDR_DATA_C   = 8'h08;
  localparam logic [7:0] ADDR_DATA_D   = 8'h0C;
  localparam logic [7:0] ADDR_DIR_A    = 8'h10;
  localparam logic [7:0] ADDR_DIR_B    = 8'h14;
  localparam logic [7:0] ADDR_DIR_C    = 8'h18;
  localparam logic [7:0] ADDR_OPTIONS  = 8'h1C;
  localparam logic [7:0] ADDR_EVENTS   = 8'h20;

  localparam logic [7:0] DIR_RESET     = 8'h00;
  localparam logic [7:0] DATA_RESET    = 8'h00;
  localparam logic [7:0] D_IMPL_MASK   = 8'hBF;

  // Option register fields
  localparam int OPT_IRQ_LEVEL_BIT = 8;
  localparam int OPT_PULL_LSB      = 0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int SYNC_STAGES = 2;

endpackage

// [verification/ppb_board.sv]
`timescale 1ns/10ps
module ppb_board (
  input  wire logic [7:0] firstPortOut,
  input  wire logic [7:0] firstPortOe,
  input  wire logic [7:0] secondPortOut,
  input  wire logic [7:0] secondPortOe,
  input  wire logic [7:0] thirdPortOut,
  input  wire logic [7:0] thirdPortOe,
  input  wire logic [7:0] extA,
  input  wire logic [7:0] extB,
  input  wire logic [7:0] extC,
  output logic      [7:0] firstPortIn,
  output logic      [7:0] secondPortIn,
  output logic      [7:0] thirdPortIn
);
  // Board drives only lines the device has released, no contention
  function automatic logic [7:0] lvl(input logic [7:0] o, e, x);
    return (o & e) | (x & ~e);
  endfunction
  assign firstPortIn  = lvl(firstPortOut, firstPortOe, extA);
  assign secondPortIn = lvl(secondPortOut, secondPortOe, extB);
  assign thirdPortIn  = lvl(thirdPortOut, thirdPortOe, extC);
endmodule

// [verification/ppb_checker_assertions.sv]
`timescale 1ns/10ps
module ppb_checker #(
  parameter logic [7:0] PULL_OPTIONS = 8'hFF,
  parameter logic       IRQ_LEVEL    = 1'h1
) (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       clkEn,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic [7:0] firstPortOe,
  input wire logic [7:0] secondPortOe,
  input wire logic [7:0] thirdPortOe,
  input wire logic [7:0] secondPortPullEn,
  input wire logic [7:0] inputOnlyLines,
  input wire logic       irqPinN,
  input wire logic [1:0] asyncSerialLines,
  input wire logic [3:0] spiLines,
  input wire logic       busClkEn,
  input wire logic       extIrqReq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_low; (IRQ_LEVEL && !irqPinN) [*5]; endsequence
  sequence s_high; irqPinN [*5]; endsequence
  // Sync plus output flop needs three edges to settle
  sequence s_calm; $stable(inputOnlyLines) [*4]; endsequence
  bus_clk_tog_a: assert property (clkEn |=> busClkEn != $past(busClkEn))
    else $error("bus clock enable stuck");
  dir_reset_a: assert property ($past(rst) |->
    {firstPortOe, secondPortOe, thirdPortOe} == 24'h0)
    else $error("line driven after reset");
  dir_by_write_a: assert property (
    $changed({firstPortOe, secondPortOe, thirdPortOe}) |-> ##[0:2] s_axi_bvalid)
    else $error("direction changed without a write");
  pull_fixed_a: assert property (secondPortPullEn == PULL_OPTIONS)
    else $error("pullup enable not the fixed option");
  lines_route_a: assert property (s_calm |->
    asyncSerialLines == inputOnlyLines[1:0] && spiLines == inputOnlyLines[5:2])
    else $error("shared input lines misrouted");
  ext_edge_a: assert property ($fell(irqPinN) |-> ##[1:4] extIrqReq)
    else $error("falling edge missed");
  ext_level_a: assert property (s_low |-> extIrqReq)
    else $error("low level not requested");
  ext_quiet_a: assert property (s_high |-> !extIrqReq)
    else $error("request while pin idle");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read response dropped");
endmodule
bind ppb_top ppb_checker #(.PULL_OPTIONS(PULL_OPTIONS), .IRQ_LEVEL(IRQ_LEVEL)) u_chk (.*);

// [verification/ppb_top_tb.sv]
`timescale 1ns/10ps
module ppb_top_tb;
  localparam logic [7:0] PULL = 8'h0F;
  logic        clk_sys, busClkEn, portIrqReq, extIrqReq, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        rst = 1'h1, clkEn = 1'h1, irqPinN = 1'h1, s_axi_awvalid = 1'h0;
  logic        s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, asyncSerialLines;
  logic [3:0]  spiLines, s_axi_wstrb = 4'hF;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, inputOnlyLines = 8'h0;
  logic [7:0]  extA = 8'h0, extB = 8'hFF, extC = 8'h0;
  logic [7:0]  firstPortIn, firstPortOut, firstPortOe, secondPortIn, secondPortOut;
  logic [7:0]  secondPortOe, secondPortPullEn, thirdPortIn, thirdPortOut, thirdPortOe;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  int          failures, n_tests;
  logic        edgeIrqReq;
  logic [1:0]  bRespSeen;
  ppb_top #(.PULL_OPTIONS(PULL), .IRQ_LEVEL(1'h1)) u_dut (.*);
  // Second build with the edge-only external interrupt option
  ppb_top #(.PULL_OPTIONS(PULL), .IRQ_LEVEL(1'h0)) u_dut_edge (
    .*,
    .s_axi_awready    (),
    .s_axi_wready     (),
    .s_axi_bresp      (),
    .s_axi_bvalid     (),
    .s_axi_arready    (),
    .s_axi_rdata      (),
    .s_axi_rresp      (),
    .s_axi_rvalid     (),
    .firstPortOut     (),
    .firstPortOe      (),
    .secondPortOut    (),
    .secondPortOe     (),
    .secondPortPullEn (),
    .thirdPortOut     (),
    .thirdPortOe      (),
    .asyncSerialLines (),
    .spiLines         (),
    .busClkEn         (),
    .portIrqReq       (),
    .extIrqReq        (edgeIrqReq)
  );
  ppb_board u_board (.*);
  initial
  begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    n = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      n++;
    end while (!s_axi_bvalid && n < 40);
    bRespSeen = s_axi_bresp;
    s_axi_bready <= 1'h0;
    if (n == 40)
    begin
      failures++;
      finish_test();
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk_sys);
    n = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      n++;
    end while (!s_axi_rvalid && n < 40);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    if (n == 40)
    begin
      failures++;
      finish_test();
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(n, e, d);
    chk({n, " resp"}, {30'h0, ppb_pkg::RESP_OKAY}, {30'h0, r});
  endtask
  task automatic t_rst(input logic pulse);
    logic b;
    if (pulse)
    begin
      @(posedge clk_sys);
      rst <= 1'h1;
      repeat (2) @(posedge clk_sys);
      chk("oe in reset", 24'h0, {firstPortOe, secondPortOe, thirdPortOe});
      chk("out in reset", 24'h0, {firstPortOut, secondPortOut, thirdPortOut});
      rst <= 1'h0;
    end
    @(posedge clk_sys);
    b = busClkEn;
    @(posedge clk_sys);
    chk("bus clock", {31'h0, ~b}, {31'h0, busClkEn});
    chk("ext irq idle", 32'h0, {31'h0, extIrqReq});
    chk("oe", 24'h0, {firstPortOe, secondPortOe, thirdPortOe});
    // Odd number of edges, so a phase that ignores the enable is caught
    clkEn <= 1'h0;
    repeat (2) @(posedge clk_sys);
    b = busClkEn;
    repeat (3) @(posedge clk_sys);
    chk("frozen clock", {31'h0, b}, {31'h0, busClkEn});
    clkEn <= 1'h1;
    for (int i = 0; i < 3; i++)
      rc(ppb_pkg::ADDR_DIR_A + 8'(4 * i), 32'h0, "dir");
    $display("reset test done");
  endtask
  task automatic t_dir();
    logic [7:0] dir [3];
    logic [7:0] e;
    dir = '{8'h5A, 8'hA5, 8'h3C};
    extA <= 8'h96;
    extC <= 8'h96;
    extB <= 8'h96;
    for (int i = 0; i < 3; i++)
    begin
      wr(ppb_pkg::ADDR_DATA_A + 8'(4 * i), 32'hC3);
      wr(ppb_pkg::ADDR_DIR_A + 8'(4 * i), {24'h0, dir[i]});
    end
    repeat (4) @(posedge clk_sys);
    chk("oe pins", 24'h5AA53C, {firstPortOe, secondPortOe, thirdPortOe});
    chk("out pins", 24'hC3C3C3, {firstPortOut, secondPortOut, thirdPortOut});
    for (int i = 0; i < 3; i++)
    begin
      e = (8'hC3 & dir[i]) | (8'h96 & ~dir[i]);
      rc(ppb_pkg::ADDR_DATA_A + 8'(4 * i), {24'h0, e}, "data");
    end
    $display("direction test done");
  endtask
  task automatic t_d();
    logic [7:0] v;
    for (int i = 0; i < 2; i++)
    begin
      v = i ? 8'h55 : 8'hFF;
      inputOnlyLines <= v;
      repeat (4) @(posedge clk_sys);
      chk("serial", {30'h0, v[1:0]}, {30'h0, asyncSerialLines});
      chk("spi", {28'h0, v[5:2]}, {28'h0, spiLines});
      wr(ppb_pkg::ADDR_DATA_D, 32'h0);
      chk("port4 write", {30'h0, ppb_pkg::RESP_OKAY}, {30'h0, bRespSeen});
      rc(ppb_pkg::ADDR_DATA_D, {24'h0, v & 8'hBF}, "port4");
    end
    $display("input port test done");
  endtask
  task automatic t_opt();
    logic [31:0] d;
    logic [1:0]  r;
    rc(ppb_pkg::ADDR_OPTIONS, {23'h0, 1'h1, PULL}, "options");
    chk("pull", {24'h0, PULL}, {24'h0, secondPortPullEn});
    wr(ppb_pkg::ADDR_DIR_B, 32'h0);
    extB <= 8'hFF;
    repeat (4) @(posedge clk_sys);
    wr(ppb_pkg::ADDR_EVENTS, 32'hFF);
    rc(ppb_pkg::ADDR_EVENTS, 32'h0, "events idle");
    // Bit 7 falls too but has no option, so only bit 0 may flag
    extB <= 8'h7E;
    repeat (4) @(posedge clk_sys);
    rc(ppb_pkg::ADDR_EVENTS, 32'h1, "event");
    chk("port irq", 32'h1, {31'h0, portIrqReq});
    wr(ppb_pkg::ADDR_EVENTS, 32'h1);
    rc(ppb_pkg::ADDR_EVENTS, 32'h0, "event clear");
    chk("port irq clear", 32'h0, {31'h0, portIrqReq});
    rd(8'h24, d, r);
    chk("unmapped", {30'h0, ppb_pkg::RESP_SLVERR}, {30'h0, r});
    wr(8'h24, 32'h0);
    chk("unmapped write", {30'h0, ppb_pkg::RESP_SLVERR}, {30'h0, bRespSeen});
    irqPinN <= 1'h0;
    repeat (4) @(posedge clk_sys);
    chk("irq edge pulse", 32'h1, {31'h0, edgeIrqReq});
    repeat (2) @(posedge clk_sys);
    chk("irq level", 32'h1, {31'h0, extIrqReq});
    chk("irq edge only", 32'h0, {31'h0, edgeIrqReq});
    irqPinN <= 1'h1;
    repeat (6) @(posedge clk_sys);
    chk("irq idle", 32'h0, {31'h0, extIrqReq});
    $display("option test done");
  endtask
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'h0;
    t_rst(1'h0);
    t_dir();
    t_rst(1'h1);
    t_d();
    t_opt();
    finish_test();
  end
endmodule

// [verilog/ppb_sync.sv]
`timescale 1ns/10ps
module ppb_sync #(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         clkEn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed
  {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } ppbs_state_s;

  ppbs_state_s state_r;
  ppbs_state_s state_nxt;

  // First stage is read only by the second
  always_comb
  begin
    state_nxt = state_r;
    if (clkEn)
    begin
      state_nxt.meta   = din;
      state_nxt.stable = state_r.meta;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign dout = state_r.stable;

endmodule

// [verilog/ppb_top.sv]
`timescale 1ns/10ps
// Function
// - Bus clock enable toggles on every system clock that has clkEn high.
// - Each line of three bidirectional ports has a software direction bit.
// - First port lines all input after reset.
// - Second port lines all input after reset.
// - Third port lines all input after reset.
// - Second port pullup and pin interrupt share one option bit per line.
// - Eight fixed per-line options select second port pullup and interrupt.
// - Fourth port has seven input lines; bit 6 absent.
// - Input lines 0-1 go to serial unit, 2-5 to SPI unit.
// - External interrupt fixed as edge-only or edge-and-level sensitive.
// - Reset returns everything, directions included, to startup state.
module ppb_top #(
  parameter logic [7:0] PULL_OPTIONS = 8'hFF,
  parameter logic       IRQ_LEVEL    = 1'b1
) (
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  input  wire logic                          clkEn,
  // AXI4-Lite slave
  input  wire logic [ppb_pkg::ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [ppb_pkg::DATA_W-1:0]    s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [ppb_pkg::ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [ppb_pkg::DATA_W-1:0]         s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // Pins
  input  wire logic [7:0]                    firstPortIn,
  output logic      [7:0]                    firstPortOut,
  output logic      [7:0]                    firstPortOe,
  input  wire logic [7:0]                    secondPortIn,
  output logic      [7:0]                    secondPortOut,
  output logic      [7:0]                    secondPortOe,
  output logic      [7:0]                    secondPortPullEn,
  input  wire logic [7:0]                    thirdPortIn,
  output logic      [7:0]                    thirdPortOut,
  output logic      [7:0]                    thirdPortOe,
  input  wire logic [7:0]                    inputOnlyLines,
  input  wire logic                          irqPinN,
  output logic      [1:0]                    asyncSerialLines,
  output logic      [3:0]                    spiLines,
  output logic                               busClkEn,
  output logic                               portIrqReq,
  output logic                               extIrqReq
);

  localparam int NPB = 3;

  typedef struct packed
  {
    logic                          busPhase;
    logic [NPB-1:0][7:0]           dataOut;
    logic [NPB-1:0][7:0]           dirOut;
    logic [7:0]                    bPrev;
    logic                          irqPrev;
    logic [7:0]                    bEvents;
    logic                          extEvent;
    logic                          portIrq;
    logic                          extIrq;
    logic [1:0]                    serialOut;
    logic [3:0]                    spiOut;
    logic                          awHeld;
    logic [ppb_pkg::ADDR_W-1:0]    awAddr;
    logic                          wHeld;
    logic [ppb_pkg::DATA_W-1:0]    wData;
    logic [3:0]                    wStrb;
    logic                          bValid;
    logic [1:0]                    bResp;
    logic                          rValid;
    logic [ppb_pkg::DATA_W-1:0]    rData;
    logic [1:0]                    rResp;
  } ppb_state_s;

  ppb_state_s state_r;
  ppb_state_s state_nxt;

  logic [NPB-1:0][7:0] pinSync;
  logic [7:0]          dSync;
  logic                irqAct;
  logic [NPB-1:0][7:0] pinIn;
  logic [7:0]          pullMask;
  logic [7:0]          bFall;
  logic                irqFall;

  assign pinIn[0] = firstPortIn;
  assign pinIn[1] = secondPortIn;
  assign pinIn[2] = thirdPortIn;

  genvar gi;
  generate
    for (gi = 0; gi < NPB; gi++)
    begin : g_sync
      ppb_sync #(.W(8)) u_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .clkEn   (clkEn),
        .din     (pinIn[gi]),
        .dout    (pinSync[gi])
      );
    end
  endgenerate

  ppb_sync #(.W(9)) u_sync_d (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clkEn   (clkEn),
    .din     ({~irqPinN, inputOnlyLines}),
    .dout    ({irqAct, dSync})
  );
  // Pin inverted so a cleared synchroniser reads idle, no request after reset

  // One fixed option bit per line drives both pullup and interrupt
  assign pullMask = PULL_OPTIONS;

  // Read value of a bidirectional port: driven lines show the latch
  function automatic logic [7:0] portView(input logic [7:0] dir, input logic [7:0] lat,
                                          input logic [7:0] pin);
    portView = (dir & lat) | (~dir & pin);
  endfunction

  function automatic logic [7:0] byteMerge(input logic [7:0] old, input logic [31:0] wd,
                                           input logic [3:0] st);
    byteMerge = st[0] ? wd[7:0] : old;
  endfunction

  // Falling edges of enabled second-port inputs request an interrupt
  assign bFall   = state_r.bPrev & ~pinSync[1] & pullMask & ~state_r.dirOut[1];
  assign irqFall = ~state_r.irqPrev & irqAct;

  always_comb
  begin
    logic [7:0] ra;
    logic [7:0] wa;
    logic       wrHit;
    logic       wrOk;
    logic       rdOk;
    logic [7:0] rdByte;
    logic [31:0] rdWord;
    ra     = s_axi_araddr;
    wa     = state_r.awAddr;
    wrHit  = 1'b0;
    wrOk   = 1'b1;
    rdOk   = 1'b1;
    rdByte = 8'h00;
    rdWord = 32'h0000_0000;
    state_nxt = state_r;
    if (clkEn)
    begin
      state_nxt.busPhase = ~state_r.busPhase;
      state_nxt.bPrev    = pinSync[1];
      state_nxt.irqPrev  = irqAct;
      state_nxt.serialOut = dSync[1:0];
      state_nxt.spiOut    = dSync[5:2];
      // Edge gives a one-cycle request; level mode also holds while the pin stays low
      state_nxt.extIrq = irqFall | (IRQ_LEVEL & irqAct);
      state_nxt.portIrq = |state_r.bEvents;

      if (s_axi_awvalid && !state_r.awHeld)
      begin
        state_nxt.awHeld = 1'b1;
        state_nxt.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !state_r.wHeld)
      begin
        state_nxt.wHeld = 1'b1;
        state_nxt.wData = s_axi_wdata;
        state_nxt.wStrb = s_axi_wstrb;
      end

      wrHit = state_r.awHeld && state_r.wHeld && !state_r.bValid;
      if (wrHit)
      begin
        case (wa)
          ppb_pkg::ADDR_DATA_A:
            state_nxt.dataOut[0] = byteMerge(state_r.dataOut[0], state_r.wData, state_r.wStrb);
          ppb_pkg::ADDR_DATA_B:
            state_nxt.dataOut[1] = byteMerge(state_r.dataOut[1], state_r.wData, state_r.wStrb);
          ppb_pkg::ADDR_DATA_C:
            state_nxt.dataOut[2] = byteMerge(state_r.dataOut[2], state_r.wData, state_r.wStrb);
          ppb_pkg::ADDR_DIR_A:
            state_nxt.dirOut[0] = byteMerge(state_r.dirOut[0], state_r.wData, state_r.wStrb);
          ppb_pkg::ADDR_DIR_B:
            state_nxt.dirOut[1] = byteMerge(state_r.dirOut[1], state_r.wData, state_r.wStrb);
          ppb_pkg::ADDR_DIR_C:
            state_nxt.dirOut[2] = byteMerge(state_r.dirOut[2], state_r.wData, state_r.wStrb);
          ppb_pkg::ADDR_DATA_D,
          ppb_pkg::ADDR_OPTIONS:
            wrOk = 1'b1;
          ppb_pkg::ADDR_EVENTS:
            wrOk = 1'b1;
          default:
            wrOk = 1'b0;
        endcase
        state_nxt.awHeld = 1'b0;
        state_nxt.wHeld  = 1'b0;
        state_nxt.bValid = 1'b1;
        state_nxt.bResp  = wrOk ? ppb_pkg::RESP_OKAY : ppb_pkg::RESP_SLVERR;
      end
      else if (state_r.bValid && s_axi_bready)
      begin
        state_nxt.bValid = 1'b0;
      end

      // Write-one-to-clear events; a new edge in the same cycle wins
      state_nxt.bEvents = state_r.bEvents;
      if (wrHit && wa == ppb_pkg::ADDR_EVENTS && state_r.wStrb[0])
      begin
        state_nxt.bEvents = state_r.bEvents & ~state_r.wData[7:0];
      end
      state_nxt.bEvents = state_nxt.bEvents | bFall;

      if (s_axi_arvalid && !state_r.rValid)
      begin
        case (ra)
          ppb_pkg::ADDR_DATA_A:
            rdByte = portView(state_r.dirOut[0], state_r.dataOut[0], pinSync[0]);
          ppb_pkg::ADDR_DATA_B:
            rdByte = portView(state_r.dirOut[1], state_r.dataOut[1], pinSync[1]);
          ppb_pkg::ADDR_DATA_C:
            rdByte = portView(state_r.dirOut[2], state_r.dataOut[2], pinSync[2]);
          ppb_pkg::ADDR_DATA_D:
            rdByte = dSync & ppb_pkg::D_IMPL_MASK;
          ppb_pkg::ADDR_DIR_A:
            rdByte = state_r.dirOut[0];
          ppb_pkg::ADDR_DIR_B:
            rdByte = state_r.dirOut[1];
          ppb_pkg::ADDR_DIR_C:
            rdByte = state_r.dirOut[2];
          ppb_pkg::ADDR_OPTIONS:
            rdByte = pullMask;
          ppb_pkg::ADDR_EVENTS:
            rdByte = state_r.bEvents;
          default:
            rdOk = 1'b0;
        endcase
        rdWord = {24'h00_0000, rdByte};
        if (ra == ppb_pkg::ADDR_OPTIONS)
        begin
          rdWord[ppb_pkg::OPT_IRQ_LEVEL_BIT] = IRQ_LEVEL;
        end
        state_nxt.rValid = 1'b1;
        state_nxt.rData  = rdWord;
        state_nxt.rResp  = rdOk ? ppb_pkg::RESP_OKAY : ppb_pkg::RESP_SLVERR;
      end
      else if (state_r.rValid && s_axi_rready)
      begin
        state_nxt.rValid = 1'b0;
      end
    end
  end

  // Async reset puts all directions to input and clears latches
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign s_axi_awready    = clkEn & ~state_r.awHeld;
  assign s_axi_wready     = clkEn & ~state_r.wHeld;
  assign s_axi_bvalid     = state_r.bValid;
  assign s_axi_bresp      = state_r.bResp;
  assign s_axi_arready    = clkEn & ~state_r.rValid;
  assign s_axi_rvalid     = state_r.rValid;
  assign s_axi_rdata      = state_r.rData;
  assign s_axi_rresp      = state_r.rResp;
  assign firstPortOut     = state_r.dataOut[0];
  assign firstPortOe      = state_r.dirOut[0];
  assign secondPortOut    = state_r.dataOut[1];
  assign secondPortOe     = state_r.dirOut[1];
  assign secondPortPullEn = pullMask;
  assign thirdPortOut     = state_r.dataOut[2];
  assign thirdPortOe      = state_r.dirOut[2];
  assign asyncSerialLines = state_r.serialOut;
  assign spiLines         = state_r.spiOut;
  assign busClkEn         = state_r.busPhase;
  assign portIrqReq       = state_r.portIrq;
  assign extIrqReq        = state_r.extIrq;

endmodule
